// ===== verilog/pvc_conditioning.sv
// Purpose: position actual value conditioning for three encoder channels
// Assumes: enc_valid pulses carry signed increment deltas; one clock, aclk
// Notes: registers over AXI4-Lite; probe and abs adjust per channel
// Behaviour
// - scale encoder increments into neutral length units
// - condition on valid samples regardless of enable
// - encoder select picks channel one to three
// - drive each channel's encoder control word
// - scale by units, numerator and denominator
// - offset activate rising edge adds offset
// - add position offset, backlash when positioner
// - set command holds setting, increments dropped
// - invert option; negative denominator reverses motion
// - four indexes: zero control, one-three encoders
// - index zero equals assigned channel value
// - start bit two, report done bit three
// - probe only on unassigned channels, selectable
// - probe value usable while valid bit set
// - two further encoders acquired in parallel
// - per channel velocity and absolute offset
// - only index zero reference to positioner
// - positioner drives offset value and activate
// - positioner active forces position control active
`timescale 1ns/100ps
`default_nettype none
module pvc_conditioning (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // encoder evaluation side, one lane per channel
  input wire logic [2:0] enc_valid,
  input wire logic [2:0][31:0] enc_delta,
  input wire logic [3:0] probe_pins,
  input wire logic [2:0] offset_activate_in,
  input wire logic [2:0] set_position_cmd,
  output logic [2:0][15:0] encoder_ctrl_word_out,
  // positioner side
  input wire logic positioner_module_active,
  input wire logic [31:0] positioner_offset_out,
  input wire logic positioner_offset_act_bit,
  input wire logic [31:0] backlash_comp_out,
  output logic [31:0] positioner_ref_coord,
  output logic poscontrol_module_active,
  output logic [31:0] position_actual_out
);
  // global settings
  logic [1:0] enc_select, next_enc_select;
  logic [31:0] units_per_load_rev, next_units_per_load_rev;
  logic [31:0] load_gear_numerator, next_load_gear_numerator;
  logic [31:0] load_gear_denominator, next_load_gear_denominator;
  logic [1:0] glb_ctl, next_glb_ctl;
  logic [31:0] ref_point_coord_src, next_ref_point_coord_src;
  // per-channel settings and state
  logic [15:0] ch_ctl [3];
  logic [15:0] next_ch_ctl [3];
  logic [31:0] offset_value_in [3];
  logic [31:0] next_offset_value_in [3];
  logic [31:0] position_setting_value [3];
  logic [31:0] next_position_setting_value [3];
  logic [31:0] position_offset_in [3];
  logic [31:0] next_position_offset_in [3];
  logic [31:0] abs_position_offset [3];
  logic [31:0] next_abs_position_offset [3];
  logic [31:0] accum [3];  // conditioned position before offset
  logic [31:0] next_accum [3];
  logic [31:0] act [3];  // actual value, index 1..3
  logic [31:0] next_act [3];
  logic [31:0] velocity_actual_out [3];
  logic [31:0] next_velocity_actual_out [3];
  logic [31:0] probe_measured_value [3];
  logic [31:0] next_probe_measured_value [3];
  logic [2:0] act_prev, next_act_prev;  // offset activate history
  logic [2:0] prb_prev, next_prb_prev;  // probe source history
  // bus state
  logic aw_rdy, next_aw_rdy;
  logic b_vld, next_b_vld;
  logic [1:0] b_resp, next_b_resp;
  logic ar_rdy, next_ar_rdy;
  logic r_vld, next_r_vld;
  logic [31:0] r_data, next_r_data;
  logic [1:0] r_resp, next_r_resp;
  // outputs
  logic [2:0][15:0] next_cw_out;
  logic [31:0] next_ref_coord;
  logic next_pc_active;
  logic [31:0] next_pos_out;
  // helper terms
  logic [1:0] sel_ch;  // assigned channel, 0..2
  logic wr_fire, rd_fire;
  logic [2:0] set_eff, act_eff;
  logic [31:0] off_val_eff [3];
  logic [31:0] pos_off_eff [3];

  // select value 1..3 maps to channel 0..2; anything else means encoder 1
  function automatic logic [1:0] sel_to_ch(input logic [1:0] s);
    sel_to_ch = (s == 2'h2) ? 2'h1 : ((s == 2'h3) ? 2'h2 : 2'h0);
  endfunction

  // increments to length units; 96-bit product keeps overflow out of the ratio
  function automatic logic [31:0] scale(input logic [31:0] d, input logic [31:0] u,
                                        input logic [31:0] num, input logic [31:0] den,
                                        input logic inv);
    logic signed [95:0] p;
    logic signed [95:0] q;
    p = 96'($signed(d)) * 96'($signed(u)) * 96'($signed(den));
    q = (num == 32'h0) ? p : p / 96'($signed(num));
    scale = inv ? 32'(-q) : q[31:0];
  endfunction

  // map bus index to channel; index 0 follows the assigned channel
  function automatic logic [1:0] idx_to_ch(input logic [1:0] idx, input logic [1:0] sc);
    idx_to_ch = (idx == 2'h0) ? sc : 2'(idx - 2'h1);
  endfunction

  assign sel_ch = sel_to_ch(enc_select);
  assign wr_fire = aw_rdy & s_axi_awvalid & s_axi_wvalid;
  assign rd_fire = ar_rdy & s_axi_arvalid;

  // positioner wiring applies only to the channel under position control
  always_comb begin
    for (int c = 0; c < pvc_pkg::NUM_CH; c++) begin
      if (positioner_module_active && c == int'(sel_ch)) begin
        off_val_eff[c] = positioner_offset_out;
        act_eff[c] = positioner_offset_act_bit;
      end else begin
        off_val_eff[c] = offset_value_in[c];
        act_eff[c] = offset_activate_in[c];
      end
      if (positioner_module_active && c == int'(sel_ch)) begin
        pos_off_eff[c] = backlash_comp_out;
      end else begin
        pos_off_eff[c] = position_offset_in[c];
      end
      set_eff[c] = set_position_cmd[c];
    end
  end

  // bus handshake: one write and one read at a time, answer one cycle after accept
  always_comb begin
    next_aw_rdy = 1'b0;
    next_b_vld = b_vld;
    next_ar_rdy = 1'b0;
    next_r_vld = r_vld;
    // accept address and data together, a one-cycle ready pulse
    if (!aw_rdy && !b_vld && s_axi_awvalid && s_axi_wvalid) begin
      next_aw_rdy = 1'b1;
    end
    if (wr_fire) begin
      next_b_vld = 1'b1;
    end else if (b_vld && s_axi_bready) begin
      next_b_vld = 1'b0;
    end
    if (!ar_rdy && !r_vld && s_axi_arvalid) begin
      next_ar_rdy = 1'b1;
    end
    if (rd_fire) begin
      next_r_vld = 1'b1;
    end else if (r_vld && s_axi_rready) begin
      next_r_vld = 1'b0;
    end
  end

  // register writes, conditioning and capture share one next-state process
  always_comb begin
    logic [1:0] wc;
    logic [4:0] wo;
    logic hit;
    logic [31:0] dl;
    logic psig;
    logic pedge;
    logic [15:0] wmask;
    wc = 2'h0;
    wo = 5'h0;
    hit = 1'b0;
    dl = 32'h0;
    psig = 1'b0;
    pedge = 1'b0;
    wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    next_enc_select = enc_select;
    next_units_per_load_rev = units_per_load_rev;
    next_load_gear_numerator = load_gear_numerator;
    next_load_gear_denominator = load_gear_denominator;
    next_glb_ctl = glb_ctl;
    next_ref_point_coord_src = ref_point_coord_src;
    next_b_resp = b_resp;
    next_act_prev = act_eff;
    next_prb_prev = prb_prev;
    for (int c = 0; c < pvc_pkg::NUM_CH; c++) begin
      next_ch_ctl[c] = ch_ctl[c];
      next_offset_value_in[c] = offset_value_in[c];
      next_position_setting_value[c] = position_setting_value[c];
      next_position_offset_in[c] = position_offset_in[c];
      next_abs_position_offset[c] = abs_position_offset[c];
      next_velocity_actual_out[c] = velocity_actual_out[c];
      next_probe_measured_value[c] = probe_measured_value[c];
      next_accum[c] = accum[c];
    end
    // address decode: four index blocks then global words
    if (wr_fire) begin
      next_b_resp = pvc_pkg::RESP_OKAY;
      wc = idx_to_ch(s_axi_awaddr[6:5], sel_ch);
      wo = s_axi_awaddr[4:0];
      hit = !s_axi_awaddr[7];
      if (!hit && s_axi_awaddr == pvc_pkg::ADDR_ENC_SELECT) begin
        if (s_axi_wstrb[0]) begin
          next_enc_select = s_axi_wdata[1:0];
        end
      end else if (!hit && s_axi_awaddr == pvc_pkg::ADDR_UNITS_REV) begin
        next_units_per_load_rev = s_axi_wdata;
      end else if (!hit && s_axi_awaddr == pvc_pkg::ADDR_GEAR_NUM) begin
        next_load_gear_numerator = s_axi_wdata;
      end else if (!hit && s_axi_awaddr == pvc_pkg::ADDR_GEAR_DEN) begin
        next_load_gear_denominator = s_axi_wdata;
      end else if (!hit && s_axi_awaddr == pvc_pkg::ADDR_GLOBAL) begin
        if (s_axi_wstrb[0]) begin
          next_glb_ctl = s_axi_wdata[1:0];
        end
      end else if (!hit && s_axi_awaddr == pvc_pkg::ADDR_REF_SRC) begin
        next_ref_point_coord_src = s_axi_wdata;
      end else if (hit && wo == pvc_pkg::OFF_CTRL) begin
        // done and probe-valid are write-one-to-clear; events below win
        next_ch_ctl[wc] = (ch_ctl[wc] & ~(pvc_pkg::CTL_WR_MASK & wmask))
                          | (s_axi_wdata[15:0] & pvc_pkg::CTL_WR_MASK & wmask);
        if (s_axi_wstrb[0] && s_axi_wdata[pvc_pkg::CTL_ABS_DONE]) begin
          next_ch_ctl[wc][pvc_pkg::CTL_ABS_DONE] = 1'b0;
        end
        if (s_axi_wstrb[1] && s_axi_wdata[pvc_pkg::CTL_PRB_VALID]) begin
          next_ch_ctl[wc][pvc_pkg::CTL_PRB_VALID] = 1'b0;
        end
      end else if (hit && wo == pvc_pkg::OFF_OFFSET_VALUE) begin
        next_offset_value_in[wc] = s_axi_wdata;
      end else if (hit && wo == pvc_pkg::OFF_SET_VALUE) begin
        next_position_setting_value[wc] = s_axi_wdata;
      end else if (hit && wo == pvc_pkg::OFF_POS_OFFSET) begin
        next_position_offset_in[wc] = s_axi_wdata;
      end else if (hit && wo == pvc_pkg::OFF_ABS_OFFSET) begin
        next_abs_position_offset[wc] = s_axi_wdata;
      end else if (hit && (wo == pvc_pkg::OFF_ACTUAL || wo == pvc_pkg::OFF_VELOCITY
                           || wo == pvc_pkg::OFF_PROBE)) begin
        next_b_resp = pvc_pkg::RESP_OKAY;  // read-only words ignore writes
      end else begin
        next_b_resp = pvc_pkg::RESP_SLVERR;
      end
    end
    // all three channels conditioned side by side
    for (int c = 0; c < pvc_pkg::NUM_CH; c++) begin
      dl = scale(enc_delta[c], units_per_load_rev, load_gear_numerator,
                 load_gear_denominator, ch_ctl[c][pvc_pkg::CTL_INVERT]);
      if (set_eff[c]) begin
        // held at setting; incoming increments are lost for good
        next_accum[c] = position_setting_value[c];
      end else if (enc_valid[c] && ch_ctl[c][pvc_pkg::CTL_ABS_START]) begin
        // adjustment loads the absolute offset and reports done
        next_accum[c] = abs_position_offset[c];
        next_ch_ctl[c][pvc_pkg::CTL_ABS_START] = 1'b0;
        next_ch_ctl[c][pvc_pkg::CTL_ABS_DONE] = 1'b1;
      end else begin
        // update on valid samples, wrapping add
        if (enc_valid[c]) begin
          next_accum[c] = 32'(next_accum[c] + dl);
        end
        if (act_eff[c] && !act_prev[c]) begin
          next_accum[c] = 32'(next_accum[c] + off_val_eff[c]);
        end
      end
      // velocity as length units per sample
      if (enc_valid[c]) begin
        next_velocity_actual_out[c] = dl;
      end
      psig = probe_pins[ch_ctl[c][pvc_pkg::CTL_PRB_SRC_LO +: 2]];
      next_prb_prev[c] = psig;
      pedge = (ch_ctl[c][pvc_pkg::CTL_PRB_EDGE_LO] && psig && !prb_prev[c])
              || (ch_ctl[c][pvc_pkg::CTL_PRB_EDGE_LO + 1] && !psig && prb_prev[c]);
      if (pedge && ch_ctl[c][pvc_pkg::CTL_PRB_EN] && c != int'(sel_ch)) begin
        // capture with valid flag, set beats clear
        next_probe_measured_value[c] = act[c];
        next_ch_ctl[c][pvc_pkg::CTL_PRB_VALID] = 1'b1;
      end
    end
  end

  // actual values and outputs toward controllers
  always_comb begin
    for (int c = 0; c < pvc_pkg::NUM_CH; c++) begin
      next_act[c] = 32'(next_accum[c] + pos_off_eff[c]);
      // control word toward each evaluation channel
      next_cw_out[c] = 16'h0000;
      next_cw_out[c][pvc_pkg::CW_PRB_REQ] = ch_ctl[c][pvc_pkg::CTL_PRB_EN]
                                            && c != int'(sel_ch);
      next_cw_out[c][pvc_pkg::CW_PRB_EDGE_LO +: 2] = ch_ctl[c][pvc_pkg::CTL_PRB_EDGE_LO +: 2];
      next_cw_out[c][pvc_pkg::CW_ABS_REQ] = ch_ctl[c][pvc_pkg::CTL_ABS_START];
    end
    // index zero follows the assigned channel
    next_pos_out = next_act[sel_ch];
    // only index zero source reaches the positioner
    next_ref_coord = positioner_module_active ? ref_point_coord_src : 32'h0000_0000;
    next_pc_active = glb_ctl[pvc_pkg::GLB_PC_ENABLE] | positioner_module_active;
  end

  // read data mux, taken at the accept edge
  always_comb begin
    logic [1:0] rc;
    logic [4:0] ro;
    rc = idx_to_ch(s_axi_araddr[6:5], sel_ch);
    ro = s_axi_araddr[4:0];
    next_r_data = r_data;
    next_r_resp = r_resp;
    if (rd_fire) begin
      next_r_resp = pvc_pkg::RESP_OKAY;
      next_r_data = 32'h0000_0000;
      if (s_axi_araddr == pvc_pkg::ADDR_ENC_SELECT) begin
        next_r_data = {30'h0, enc_select};
      end else if (s_axi_araddr == pvc_pkg::ADDR_UNITS_REV) begin
        next_r_data = units_per_load_rev;
      end else if (s_axi_araddr == pvc_pkg::ADDR_GEAR_NUM) begin
        next_r_data = load_gear_numerator;
      end else if (s_axi_araddr == pvc_pkg::ADDR_GEAR_DEN) begin
        next_r_data = load_gear_denominator;
      end else if (s_axi_araddr == pvc_pkg::ADDR_GLOBAL) begin
        next_r_data = {30'h0, glb_ctl};
      end else if (s_axi_araddr == pvc_pkg::ADDR_REF_SRC) begin
        next_r_data = ref_point_coord_src;
      end else if (s_axi_araddr[7]) begin
        next_r_resp = pvc_pkg::RESP_SLVERR;
      end else if (ro == pvc_pkg::OFF_CTRL) begin
        next_r_data = {16'h0, ch_ctl[rc]};
      end else if (ro == pvc_pkg::OFF_OFFSET_VALUE) begin
        next_r_data = offset_value_in[rc];
      end else if (ro == pvc_pkg::OFF_SET_VALUE) begin
        next_r_data = position_setting_value[rc];
      end else if (ro == pvc_pkg::OFF_POS_OFFSET) begin
        next_r_data = position_offset_in[rc];
      end else if (ro == pvc_pkg::OFF_ABS_OFFSET) begin
        next_r_data = abs_position_offset[rc];
      end else if (ro == pvc_pkg::OFF_ACTUAL) begin
        next_r_data = act[rc];
      end else if (ro == pvc_pkg::OFF_VELOCITY) begin
        next_r_data = velocity_actual_out[rc];
      end else if (ro == pvc_pkg::OFF_PROBE) begin
        next_r_data = probe_measured_value[rc];
      end else begin
        next_r_resp = pvc_pkg::RESP_SLVERR;
      end
    end
  end

  // state registers, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_select <= pvc_pkg::RST_ENC_SELECT;
      units_per_load_rev <= pvc_pkg::RST_UNITS_REV;
      load_gear_numerator <= pvc_pkg::RST_GEAR_NUM;
      load_gear_denominator <= pvc_pkg::RST_GEAR_DEN;
      glb_ctl <= pvc_pkg::RST_GLOBAL;
      ref_point_coord_src <= 32'h0000_0000;
      for (int c = 0; c < pvc_pkg::NUM_CH; c++) begin
        ch_ctl[c] <= 16'h0000;
        offset_value_in[c] <= 32'h0000_0000;
        position_setting_value[c] <= 32'h0000_0000;
        position_offset_in[c] <= 32'h0000_0000;
        abs_position_offset[c] <= 32'h0000_0000;
        accum[c] <= 32'h0000_0000;
        act[c] <= 32'h0000_0000;
        velocity_actual_out[c] <= 32'h0000_0000;
        probe_measured_value[c] <= 32'h0000_0000;
      end
      act_prev <= 3'h0;
      prb_prev <= 3'h0;
      aw_rdy <= 1'b0;
      b_vld <= 1'b0;
      b_resp <= pvc_pkg::RESP_OKAY;
      ar_rdy <= 1'b0;
      r_vld <= 1'b0;
      r_data <= 32'h0000_0000;
      r_resp <= pvc_pkg::RESP_OKAY;
      encoder_ctrl_word_out <= '0;
      positioner_ref_coord <= 32'h0000_0000;
      poscontrol_module_active <= 1'b0;
      position_actual_out <= 32'h0000_0000;
    end else begin
      enc_select <= next_enc_select;
      units_per_load_rev <= next_units_per_load_rev;
      load_gear_numerator <= next_load_gear_numerator;
      load_gear_denominator <= next_load_gear_denominator;
      glb_ctl <= next_glb_ctl;
      ref_point_coord_src <= next_ref_point_coord_src;
      ch_ctl <= next_ch_ctl;
      offset_value_in <= next_offset_value_in;
      position_setting_value <= next_position_setting_value;
      position_offset_in <= next_position_offset_in;
      abs_position_offset <= next_abs_position_offset;
      accum <= next_accum;
      act <= next_act;
      velocity_actual_out <= next_velocity_actual_out;
      probe_measured_value <= next_probe_measured_value;
      act_prev <= next_act_prev;
      prb_prev <= next_prb_prev;
      aw_rdy <= next_aw_rdy;
      b_vld <= next_b_vld;
      b_resp <= next_b_resp;
      ar_rdy <= next_ar_rdy;
      r_vld <= next_r_vld;
      r_data <= next_r_data;
      r_resp <= next_r_resp;
      encoder_ctrl_word_out <= next_cw_out;
      positioner_ref_coord <= next_ref_coord;
      poscontrol_module_active <= next_pc_active;
      position_actual_out <= next_pos_out;
    end
  end

  // bus outputs straight from flops
  assign s_axi_awready = aw_rdy;
  assign s_axi_wready = aw_rdy;
  assign s_axi_bvalid = b_vld;
  assign s_axi_bresp = b_resp;
  assign s_axi_arready = ar_rdy;
  assign s_axi_rvalid = r_vld;
  assign s_axi_rdata = r_data;
  assign s_axi_rresp = r_resp;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_offset_rise0;
    act_eff[0] && !act_prev[0] && !set_eff[0] && !enc_valid[0];
  endsequence

  a_write_answer: assert property (wr_fire |=> b_vld ##0 !aw_rdy)
    else $error("write accept not answered next cycle");
  a_read_answer: assert property (rd_fire |=> r_vld)
    else $error("read accept not answered next cycle");
  a_set_hold: assert property (set_eff[0] ##1 set_eff[0]
    |-> accum[0] == $past(position_setting_value[0]))
    else $error("set command did not hold the setting");
  a_offset_edge: assert property (s_offset_rise0
    |=> accum[0] == 32'($past(accum[0]) + $past(off_val_eff[0])))
    else $error("offset edge not added once");
  a_index_mirror: assert property (##1 $stable(enc_select)
    |-> position_actual_out == act[sel_ch])
    else $error("index zero differs from assigned channel");
  a_abs_done: assert property (
    enc_valid[0] && ch_ctl[0][pvc_pkg::CTL_ABS_START] && !set_eff[0]
    |=> ch_ctl[0][pvc_pkg::CTL_ABS_DONE] && !ch_ctl[0][pvc_pkg::CTL_ABS_START]
    && accum[0] == $past(abs_position_offset[0]))
    else $error("adjustment did not complete");
  a_probe_gate: assert property ($stable(enc_select) [*2]
    |-> !encoder_ctrl_word_out[sel_ch][pvc_pkg::CW_PRB_REQ])
    else $error("probe requested on control channel");
  a_pos_module: assert property (positioner_module_active |=> poscontrol_module_active)
    else $error("positioner without position control");
endmodule
`default_nettype wire

// ===== common/pvc_pkg.sv
// Purpose: constants for position actual value conditioning
// Assumes: AXI4-Lite register access, 32-bit data, three encoder channels
// Notes: index 0 addresses whichever channel is assigned to position control
package pvc_pkg;
  // channel and width figures
  localparam int NUM_CH = 3;
  localparam int NUM_IDX = 4;
  localparam int POS_W = 32;
  localparam int CW_W = 16;
  localparam int PRB_W = 4;

  // per-index block: base is index times stride
  localparam logic [7:0] IDX_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_OFFSET_VALUE = 5'h04;
  localparam logic [4:0] OFF_SET_VALUE = 5'h08;
  localparam logic [4:0] OFF_POS_OFFSET = 5'h0C;
  localparam logic [4:0] OFF_ABS_OFFSET = 5'h10;
  localparam logic [4:0] OFF_ACTUAL = 5'h14;
  localparam logic [4:0] OFF_VELOCITY = 5'h18;
  localparam logic [4:0] OFF_PROBE = 5'h1C;

  // global registers
  localparam logic [7:0] ADDR_ENC_SELECT = 8'h80;
  localparam logic [7:0] ADDR_UNITS_REV = 8'h84;
  localparam logic [7:0] ADDR_GEAR_NUM = 8'h88;
  localparam logic [7:0] ADDR_GEAR_DEN = 8'h8C;
  localparam logic [7:0] ADDR_GLOBAL = 8'h90;
  localparam logic [7:0] ADDR_REF_SRC = 8'h94;

  // channel control word fields
  localparam int CTL_INVERT = 0;
  localparam int CTL_ABS_START = 2;
  localparam int CTL_ABS_DONE = 3;
  localparam int CTL_PRB_EN = 4;
  localparam int CTL_PRB_SRC_LO = 5;
  localparam int CTL_PRB_EDGE_LO = 8;
  localparam int CTL_PRB_VALID = 10;
  localparam logic [15:0] CTL_WR_MASK = 16'h03F5;

  // global control fields
  localparam int GLB_PC_ENABLE = 0;
  localparam int GLB_TRACKING = 1;

  // encoder control word fields driven to each evaluation channel
  localparam int CW_PRB_REQ = 0;
  localparam int CW_PRB_EDGE_LO = 1;
  localparam int CW_ABS_REQ = 3;

  // reset values
  localparam logic [1:0] RST_ENC_SELECT = 2'h1;
  localparam logic [31:0] RST_UNITS_REV = 32'h0000_2710;
  localparam logic [31:0] RST_GEAR_NUM = 32'h0000_0001;
  localparam logic [31:0] RST_GEAR_DEN = 32'h0000_0001;
  localparam logic [1:0] RST_GLOBAL = 2'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verif/pvc_enc_model.sv
// Purpose: stand-in for the three encoder evaluation lanes
// Assumes: one sample strobe for each cycle that go is high
// Notes: idle delta lines scramble so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
module pvc_enc_model (
  input wire logic aclk,
  input wire logic [2:0] go,
  input wire logic [31:0] d,
  output logic [2:0] enc_valid,
  output logic [2:0][31:0] enc_delta
);
  // one-cycle strobe, inverse of last delta while idle
  always_ff @(posedge aclk) begin
    enc_valid <= go;
    enc_delta <= (go != 3'h0) ? {3{d}} : ~enc_delta;
  end
endmodule
`default_nettype wire

// ===== verif/position_value_conditioning_test.sv
// Purpose: self-checking bench for position conditioning
// Assumes: units set to 3, numerator 1, encoder 1 assigned
// Notes: expected position kept as a running sum in e
`timescale 1ns/100ps
`default_nettype none
module position_value_conditioning_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, positioner_offset_out, backlash_comp_out, d, x, e, q;
  logic [31:0] positioner_ref_coord, position_actual_out, vl;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb, probe_pins;
  logic [2:0] enc_valid, offset_activate_in, set_position_cmd, go;
  logic [2:0][31:0] enc_delta;
  logic [2:0][15:0] encoder_ctrl_word_out;
  logic positioner_module_active, positioner_offset_act_bit, poscontrol_module_active;
  int err_total, n_tests, cyc;
  pvc_conditioning u_dut (.*);
  pvc_enc_model u_enc (.aclk, .go, .d, .enc_valid, .enc_delta);
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end
  function automatic [31:0] nx(input [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // three units per increment, sign flipped by invert or negative denominator
  function automatic [31:0] sc(input [31:0] v, input neg);
    return neg ? -(v * 3) : v * 3;
  endfunction
  task summarize;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input [31:0] ex, input [31:0] s);
    n_tests++;
    if (s !== ex) begin
      $display("ERROR %s expected %h seen %h", n, ex, s);
      err_total++;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'h3};
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    {s_axi_arvalid, s_axi_rready} <= 2'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    {x, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // back-to-back random samples on encoder 1
  task burst(input neg);
    for (int i = 0; i < 4; i++) begin
      q = nx(q);
      {go, d} <= {3'h1, {20{q[11]}}, q[11:0]};
      vl = sc({{20{q[11]}}, q[11:0]}, neg);
      e = e + vl;
      @(posedge aclk);
    end
    go <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, go, d, offset_activate_in, probe_pins} = 0;
    {set_position_cmd, positioner_module_active, positioner_offset_act_bit} = 0;
    {positioner_offset_out, backlash_comp_out, e, s_axi_wstrb, q} = {64'h0, 32'h0, 36'hF_CBBA2724};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h84);
    chk("units", 32'h2710, x);
    wr(8'h84, 32'h3);
    chk("wokay", 32'h0, {30'h0, rs});
    // plain, inverted, then negative denominator
    for (int k = 0; k < 3; k++) begin
      wr(8'h20, 32'(k == 1));
      wr(8'h8C, (k == 2) ? 32'hFFFF_FFFF : 32'h1);
      burst(k != 0);
      chk("actual", e, position_actual_out);
      rd(8'h34);
      chk("index1", e, x);
      rd(8'h14);
      chk("index0", e, x);
      rd(8'h38);
      chk("velocity", vl, x);
    end
    // set command swallows increments for good
    wr(8'h28, 32'h1234);
    set_position_cmd <= 3'h1;
    burst(1);
    chk("setpos", 32'h1234, position_actual_out);
    {set_position_cmd, e} <= {3'h0, 32'h1234};
    wr(8'h24, 32'hFFFF_FFF0);
    offset_activate_in <= 3'h1;
    repeat (3) @(posedge aclk);
    chk("offset", 32'h1224, position_actual_out);
    // operator parks the controller in tracking mode for test signals
    wr(8'h90, 32'h2);
    rd(8'h90);
    chk("global", 32'h2, x);
    chk("pcoff", 32'h0, {31'h0, poscontrol_module_active});
    {positioner_module_active, backlash_comp_out} <= {1'b1, 32'h5};
    wr(8'h94, 32'h77);
    repeat (3) @(posedge aclk);
    chk("pcact", 32'h1, {31'h0, poscontrol_module_active});
    chk("backlash", 32'h1229, position_actual_out);
    chk("refcoord", 32'h77, positioner_ref_coord);
    // probe on a free channel captures its position
    wr(8'h48, 32'h99);
    wr(8'h40, 32'h110);
    set_position_cmd <= 3'h2;
    repeat (2) @(posedge aclk);
    {set_position_cmd, probe_pins} <= {3'h0, 4'h1};
    repeat (3) @(posedge aclk);
    rd(8'h5C);
    chk("probe", 32'h99, x);
    rd(8'h40);
    chk("prbvalid", 32'h510, x);
    chk("cwprobe", 32'h3, {16'h0, encoder_ctrl_word_out[1]});
    // absolute adjustment on the next sample, then done reported
    wr(8'h30, 32'h500);
    wr(8'h20, 32'h4);
    {go, d} <= {3'h1, q};
    @(posedge aclk);
    go <= 3'h0;
    chk("abspend", 32'h8, {16'h0, encoder_ctrl_word_out[0]});
    repeat (3) @(posedge aclk);
    chk("absadj", 32'h505, position_actual_out);
    rd(8'h20);
    chk("absdone", 32'h8, x);
    rd(8'hFC);
    chk("unmapped", 32'h2, {30'h0, rs});
    wr(8'hFC, 32'h0);
    chk("wresp", 32'h2, {30'h0, rs});
    summarize;
  end
endmodule
`default_nettype wire
